/* File: hw/exec_pkg.sv */
// shared constants and types for the instruction execute block
// assumes a 125 MHz system clock and a synchronous active-high reset
package exec_pkg;
   // status flag bit positions
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;
   // i/o space offsets and the data-space alias distance
   localparam logic [5:0] STACK_POINTER_LOW_OFS = 6'h3d;
   localparam logic [5:0] STACK_POINTER_HIGH_OFS = 6'h3e;
   localparam logic [5:0] STATUS_FLAGS_OFS = 6'h3f;
   localparam logic [5:0] BIT_IO_LAST = 6'h1f;
   localparam logic [6:0] DATA_ALIAS_OFS = 7'h20;
   localparam int IO_COUNT = 64;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [10:0] SP_RESET = 11'h000;
   localparam logic [2:0] STACK_HIGH_MASK = 3'h7;
   // operation codes presented on the issue port
   typedef enum logic [4:0] {
      OP_NOP, io_bit_clear, io_bit_set, compare_skip_equal, register_compare,
      compare_with_borrow, skip_reg_bit_low, skip_reg_bit_high,
      skip_port_bit_low, skip_port_bit_high, branch_flag_high,
      branch_flag_low, branch_on_equal, unsigned_product,
      fractional_mixed_product, subroutine_return, interrupt_return,
      OP_IO_WRITE, OP_IO_READ
   } op_type;
   typedef struct packed {
      op_type op;
      logic [7:0] rd_val;    // destination operand value
      logic [7:0] rr_val;    // source operand value
      logic [6:0] addr;      // i/o or data-space address
      logic [2:0] bit_sel;   // bit or flag number
      logic [6:0] offset;    // signed branch offset
      logic next_two_word;   // following instruction is two words long
   } issue_type;
   typedef struct packed {
      logic pc_load;
      logic [15:0] pc;
      logic prod_we;
      logic [15:0] prod;
   } result_type;
endpackage

/* File: hw/io_space.sv */
// i/o register storage with set/clear-bit access and flag write-one clear
// assumes one access per cycle from the execute core
`timescale 1ns/1ps
module io_space
   import exec_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [5:0] addr,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] w1c_mask,
   input wire logic [7:0] flag_set,
   output logic [7:0] rd_data
);
   logic [7:0] mem_r [IO_COUNT];
   logic [7:0] wrote;
   assign rd_data = mem_r[addr];
   // bits under w1c_mask clear on a written one, plain bits just store
   assign wrote = (wr_data & ~w1c_mask) |
                  (mem_r[addr] & w1c_mask & ~wr_data);
   // flag_set from peripherals wins over a clearing write in the same cycle
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < IO_COUNT; i++) begin
         if (sys_rst) begin
            mem_r[i] <= 8'h00;
         end else if (wr_en && addr == 6'(i)) begin
            mem_r[i] <= wrote | (flag_set & w1c_mask);
         end else begin
            mem_r[i] <= mem_r[i] | (flag_set & w1c_mask);
         end
      end
   end
endmodule

/* File: hw/cpu_instruction_execute.sv */
// execute stage for compare, skip, branch, multiply, return and bit i/o
// assumes issue inputs are stable for the cycle issue_valid is high
`timescale 1ns/1ps
module cpu_instruction_execute
   import exec_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic issue_valid,
   input wire issue_type issue,
   input wire logic [15:0] pc_now,
   input wire logic [15:0] stack_pc,
   input wire logic [7:0] w1c_mask,
   input wire logic [7:0] flag_set,
   output result_type result_r,
   output logic [7:0] status_flags_r,
   output logic [10:0] stack_pointer_r,
   output logic [7:0] io_rd_data_r,
   output logic bad_addr_r
);
   typedef enum logic [1:0] {EXEC, PRODUCT_WAIT} state_type;
   state_type state_r, state_nxt;
   logic [15:0] prod_r;

   // subtract with borrow, returns {c,h,v,n,z} and keeps z when chaining
   function automatic logic [4:0] sub_flags(input logic [7:0] d,
      input logic [7:0] s, input logic cin, input logic zin, input logic chain);
      logic [8:0] r;
      logic h;
      logic v;
      r = {1'b0, d} - {1'b0, s} - {8'h00, cin};
      h = (~d[3] & s[3]) | (s[3] & r[3]) | (r[3] & ~d[3]);
      v = (d[7] & ~s[7] & ~r[7]) | (~d[7] & s[7] & r[7]);
      return {r[8], h, v, r[7],
              (r[7:0] == 8'h00) & (chain ? zin : 1'b1)};
   endfunction

   // i/o address: i/o ops use the raw number, data-space ops subtract 0x20
   logic is_data_view;
   logic [6:0] io_addr7;
   logic [5:0] io_addr;
   logic bit_op;
   logic io_oob;
   assign is_data_view = (issue.op == OP_IO_WRITE) ||
                         (issue.op == OP_IO_READ);
   assign io_addr7 = is_data_view ? issue.addr - DATA_ALIAS_OFS
                                  : issue.addr;
   assign io_addr = io_addr7[5:0];
   assign bit_op = (issue.op == io_bit_clear) || (issue.op == io_bit_set) ||
                   (issue.op == skip_port_bit_low) ||
                   (issue.op == skip_port_bit_high);
   assign io_oob = bit_op ? (issue.addr > {1'b0, BIT_IO_LAST})
                          : (is_data_view &&
                             (issue.addr < DATA_ALIAS_OFS ||
                              io_addr7 > 7'(IO_COUNT - 1)));

   // core-owned registers live here; the rest in io_space
   logic core_reg;
   logic [7:0] io_mem_rd;
   logic [7:0] io_rd;
   assign core_reg = io_addr >= STACK_POINTER_LOW_OFS;
   assign io_rd = (io_addr == STATUS_FLAGS_OFS) ? status_flags_r :
                  (io_addr == STACK_POINTER_HIGH_OFS) ?
                     {5'h00, stack_pointer_r[10:8]} :
                  (io_addr == STACK_POINTER_LOW_OFS) ?
                     stack_pointer_r[7:0] : io_mem_rd;

   // set/clear bit writes back the whole value read, so set flags clear
   logic [7:0] bitmask;
   logic [7:0] io_wdata;
   logic io_we;
   assign bitmask = 8'h01 << issue.bit_sel;
   assign io_wdata = (issue.op == io_bit_set) ? (io_rd | bitmask) :
                     (issue.op == io_bit_clear) ? (io_rd & ~bitmask) :
                     issue.rr_val;
   assign io_we = issue_valid && !io_oob && state_r == EXEC &&
                  (issue.op == io_bit_set || issue.op == io_bit_clear ||
                   issue.op == OP_IO_WRITE);

   io_space u_io (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .addr(io_addr),
      .wr_en(io_we && !core_reg),
      .wr_data(io_wdata),
      .w1c_mask(w1c_mask),
      .flag_set(flag_set),
      .rd_data(io_mem_rd)
   );

   // skip and branch decisions
   logic [15:0] skip_pc;
   logic [15:0] next_pc;
   logic [15:0] branch_pc;
   logic flag_bit;
   logic skip_take;
   logic branch_take;
   assign skip_pc = pc_now + (issue.next_two_word ? 16'h0003 : 16'h0002);
   assign next_pc = pc_now + 16'h0001;
   assign branch_pc = pc_now + {{9{issue.offset[6]}}, issue.offset}
                      + 16'h0001;
   assign flag_bit = status_flags_r[issue.bit_sel];
   assign skip_take =
      (issue.op == compare_skip_equal && issue.rd_val == issue.rr_val) ||
      (issue.op == skip_reg_bit_low && !issue.rr_val[issue.bit_sel]) ||
      (issue.op == skip_reg_bit_high && issue.rr_val[issue.bit_sel]) ||
      (issue.op == skip_port_bit_low && !io_oob &&
       !io_rd[issue.bit_sel]) ||
      (issue.op == skip_port_bit_high && !io_oob &&
       io_rd[issue.bit_sel]);
   assign branch_take =
      (issue.op == branch_flag_high && flag_bit) ||
      (issue.op == branch_flag_low && !flag_bit) ||
      (issue.op == branch_on_equal && status_flags_r[FLAG_Z]);

   // compare flags: s follows n xor v
   logic [4:0] cmp;
   logic cmp_op;
   logic [7:0] cmp_flags;
   assign cmp_op = issue.op == register_compare ||
                   issue.op == compare_with_borrow;
   assign cmp = sub_flags(issue.rd_val, issue.rr_val,
      (issue.op == compare_with_borrow) & status_flags_r[FLAG_C],
      status_flags_r[FLAG_Z],
      issue.op == compare_with_borrow);
   assign cmp_flags = {status_flags_r[FLAG_I], status_flags_r[FLAG_T],
                       cmp[3], cmp[2] ^ cmp[1], cmp[2], cmp[1], cmp[0],
                       cmp[4]};

   // products: mixed one treats destination as signed
   logic [15:0] uprod;
   logic signed [16:0] sprod;
   logic [15:0] prod_val;
   // operands widened to the product width so no bits are lost
   assign uprod = {8'h00, issue.rd_val} *
                  {8'h00, issue.rr_val};
   assign sprod = $signed({{9{issue.rd_val[7]}}, issue.rd_val}) *
                  $signed({9'h000, issue.rr_val});
   assign prod_val = (issue.op == fractional_mixed_product) ?
                     {sprod[14:0], 1'b0} : uprod;
   logic product_op;
   assign product_op = issue.op == unsigned_product ||
                   issue.op == fractional_mixed_product;
   logic prod_carry;
   assign prod_carry = (issue.op == fractional_mixed_product) ?
                       sprod[15] : uprod[15];

   // two-cycle multiplier: first cycle computes, second writes the pair
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         EXEC: begin
            if (issue_valid && product_op) begin
               state_nxt = PRODUCT_WAIT;
            end
         end
         PRODUCT_WAIT: begin
            state_nxt = EXEC;
         end
         default: begin
            state_nxt = EXEC;
         end
      endcase
   end

   // next status value, including direct writes to its i/o location
   logic [7:0] status_nxt;
   logic [10:0] sp_nxt;
   always_comb begin
      status_nxt = status_flags_r;
      sp_nxt = stack_pointer_r;
      if (issue_valid && state_r == EXEC) begin
         if (cmp_op) begin
            status_nxt = cmp_flags;
         end else if (product_op) begin
            status_nxt[FLAG_C] = prod_carry;
            status_nxt[FLAG_Z] = prod_val == 16'h0000;
         end else if (issue.op == interrupt_return) begin
            status_nxt[FLAG_I] = 1'b1;
         end else if (io_we && core_reg) begin
            if (io_addr == STATUS_FLAGS_OFS) begin
               status_nxt = io_wdata;
            end else if (io_addr == STACK_POINTER_HIGH_OFS) begin
               sp_nxt[10:8] = io_wdata[2:0] & STACK_HIGH_MASK;
            end else begin
               sp_nxt[7:0] = io_wdata;
            end
         end
      end
   end

   // result of this cycle; subroutine return leaves flags alone
   result_type res_nxt;
   always_comb begin
      res_nxt = '0;
      if (state_r == PRODUCT_WAIT) begin
         res_nxt.prod_we = 1'b1;
         res_nxt.prod = prod_r;
      end else if (issue_valid) begin
         res_nxt.pc_load = 1'b1;
         if (skip_take) begin
            res_nxt.pc = skip_pc;
         end else if (branch_take) begin
            res_nxt.pc = branch_pc;
         end else if (issue.op == subroutine_return ||
                      issue.op == interrupt_return) begin
            res_nxt.pc = stack_pc;
         end else begin
            res_nxt.pc = next_pc;
         end
      end
   end

   // registered outputs
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_r <= EXEC;
         result_r <= '0;
         prod_r <= 16'h0000;
         status_flags_r <= STATUS_RESET;
         stack_pointer_r <= SP_RESET;
         io_rd_data_r <= 8'h00;
         bad_addr_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         result_r <= res_nxt;
         prod_r <= prod_val;
         status_flags_r <= status_nxt;
         stack_pointer_r <= sp_nxt;
         io_rd_data_r <= io_oob ? 8'h00 : io_rd;
         bad_addr_r <= issue_valid && io_oob;
      end
   end
endmodule

/* File: bench/exec_checker.sv */
// port assertions for the instruction execute block
// assumes one clock domain and the synchronous active-high reset
`timescale 1ns/1ps
module exec_checker
   import exec_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic issue_valid,
   input wire issue_type issue,
   input wire logic [15:0] pc_now,
   input wire logic [15:0] stack_pc,
   input wire result_type result_r,
   input wire logic [7:0] status_flags_r,
   input wire logic bad_addr_r
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // candidate next pc values worked out at issue time
   logic [15:0] pc1, brt, skp;
   assign pc1 = pc_now + 16'h0001;
   assign brt = pc1 + {{9{issue.offset[6]}}, issue.offset};
   assign skp = pc_now + (issue.next_two_word ? 16'h0003 : 16'h0002);
   a_eq_taken: assert property (
      issue_valid && issue.op == branch_on_equal && status_flags_r[FLAG_Z]
      |=> result_r.pc_load && result_r.pc == $past(brt))
      else $error("taken branch pc wrong");
   a_eq_untaken: assert property (
      issue_valid && issue.op == branch_on_equal && !status_flags_r[FLAG_Z]
      |=> result_r.pc_load && result_r.pc == $past(pc1))
      else $error("untaken branch pc wrong");
   a_skip_equal: assert property (
      issue_valid && issue.op == compare_skip_equal
      && issue.rd_val == issue.rr_val
      |=> result_r.pc == $past(skp) && $stable(status_flags_r))
      else $error("compare skip wrong");
   a_cmp_zero: assert property (
      issue_valid && issue.op == register_compare
      |=> status_flags_r[FLAG_Z] == $past(issue.rd_val == issue.rr_val)
      && status_flags_r[7:6] == $past(status_flags_r[7:6]))
      else $error("compare flags wrong");
   a_ret_keep: assert property (
      issue_valid && issue.op == subroutine_return
      |=> result_r.pc == $past(stack_pc) && $stable(status_flags_r))
      else $error("return altered flags or pc");
   a_interrupt_return_ie: assert property (
      issue_valid && issue.op == interrupt_return
      |=> status_flags_r[FLAG_I] && result_r.pc == $past(stack_pc))
      else $error("interrupt return wrong");
   a_prod_late: assert property (
      issue_valid && issue.op == unsigned_product |-> ##2 result_r.prod_we
      && result_r.prod == {8'h00, $past(issue.rd_val, 2)}
      * {8'h00, $past(issue.rr_val, 2)})
      else $error("product wrong or late");
   a_bit_range: assert property (
      issue_valid && issue.op inside {io_bit_set, io_bit_clear}
      |=> bad_addr_r == $past(issue.addr > 7'h1f))
      else $error("bit op range wrong");
   c_taken: cover property (issue_valid && issue.op == branch_on_equal
      && status_flags_r[FLAG_Z]);
   c_refused: cover property (bad_addr_r);
   c_product: cover property (result_r.prod_we);
endmodule

/* File: bench/fetch_stack_model.sv */
// partner model: fetch address source and return stack
// assumes the block reports every new pc on result_r
`timescale 1ns/1ps
module fetch_stack_model
   import exec_pkg::*;
#(
   parameter logic [15:0] RETURN_PC = 16'h0240
)
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire result_type result_r,
   output logic [15:0] pc_now,
   output logic [15:0] stack_pc
);
   // a registered copy alone would lag a back-to-back issue by one
   // instruction, so a fresh load is passed straight through
   logic [15:0] pc_hold_r;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pc_hold_r <= 16'h0000;
      end else begin
         pc_hold_r <= pc_now;
      end
   end
   assign pc_now = result_r.pc_load ? result_r.pc : pc_hold_r;
   // one fixed return address; deeper stacks add nothing here
   assign stack_pc = RETURN_PC;
endmodule

/* File: bench/tb_cpu_instruction_execute.sv */
// self-checking bench for the instruction execute block
// assumes the partner model supplies fetch pc and return stack
`timescale 1ns/1ps
module tb_cpu_instruction_execute
   import exec_pkg::*;
;
   localparam logic [15:0] POPPED_PC = 16'h0240;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic issue_valid = 1'b0;
   issue_type issue = '0;
   logic [15:0] pc_now, stack_pc;
   logic [7:0] w1c_mask = 8'h00;
   logic [7:0] flag_set = 8'h00;
   result_type result_r;
   logic [7:0] status_flags_r, io_rd_data_r, sv;
   logic [10:0] stack_pointer_r;
   logic bad_addr_r;
   int errors = 0;
   int samples_checked = 0;
   // 125 MHz clock
   always #4 sys_clk = ~sys_clk;
   cpu_instruction_execute dut (.sys_clk, .sys_rst, .issue_valid, .issue,
      .pc_now, .stack_pc, .w1c_mask, .flag_set, .result_r, .status_flags_r,
      .stack_pointer_r, .io_rd_data_r, .bad_addr_r);
   fetch_stack_model #(.RETURN_PC(POPPED_PC)) mem (.sys_clk, .sys_rst,
      .result_r, .pc_now, .stack_pc);
   task automatic chk(input string n, input logic [16:0] e, g);
      samples_checked++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
         errors++;
      end
   endtask
   // v is {rd, rr}, f is {two-word, bit, offset}; dp is expected pc step
   task automatic run(input op_type op, input logic [15:0] v,
         input logic [6:0] ad, input logic [10:0] f, input logic [15:0] dp);
      logic [15:0] e;
      e = pc_now + dp;
      if (op == subroutine_return || op == interrupt_return) begin
         e = POPPED_PC;
      end
      issue_valid = 1'b1;
      issue = '{op, v[15:8], v[7:0], ad, f[9:7], f[6:0], f[10]};
      @(posedge sys_clk);
      #1;
      chk("next pc", {1'b1, e}, {result_r.pc_load, result_r.pc});
   endtask
   // idle cycle, with an optional hardware flag pulse
   task automatic idle(input logic [7:0] fs);
      issue_valid = 1'b0;
      flag_set = fs;
      @(posedge sys_clk);
      #1;
      flag_set = 8'h00;
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge sys_clk);
      #1;
      sys_rst = 1'b0;
      chk("reset", {6'h0, STATUS_RESET, 3'h0}, {6'h0, status_flags_r, 3'h0});
      chk("sp reset", {6'h0, SP_RESET}, {6'h0, stack_pointer_r});
      run(register_compare, 16'h0505, 7'h00, 11'h000, 16'h1);
      chk("z", 17'h1, {16'h0, status_flags_r[FLAG_Z]});
      run(branch_on_equal, 16'h0, 7'h00, 11'h07e, 16'hffff);
      run(register_compare, 16'h0305, 7'h00, 11'h000, 16'h1);
      chk("flags", 17'h15, {12'h0, status_flags_r[5], status_flags_r[3:0]});
      run(branch_on_equal, 16'h0, 7'h00, 11'h07e, 16'h1);
      run(compare_with_borrow, 16'h0504, 7'h00, 11'h0, 16'h1);
      chk("flags", 17'h0, {12'h0, status_flags_r[5], status_flags_r[3:0]});
      run(branch_flag_low, 16'h0, 7'h00, 11'h003, 16'h4);
      run(branch_flag_high, 16'h0, 7'h00, 11'h003, 16'h1);
      $display("compare and branch test done");
      run(compare_skip_equal, 16'h0404, 7'h00, 11'h400, 16'h3);
      run(skip_reg_bit_low, 16'h0404, 7'h00, 11'h100, 16'h1);
      run(skip_reg_bit_high, 16'h0404, 7'h00, 11'h100, 16'h2);
      $display("skip test done");
      run(unsigned_product, 16'hffff, 7'h00, 11'h0, 16'h1);
      idle(8'h00);
      chk("product", 17'h1fe01, {result_r.prod_we, result_r.prod});
      chk("z c", 17'h1, {15'h0, status_flags_r[1:0]});
      run(fractional_mixed_product, 16'h8002, 7'h00, 11'h0,
         16'h1);
      idle(8'h00);
      chk("fraction", 17'h1fe00,
         {result_r.prod_we, result_r.prod});
      chk("z c", 17'h1, {15'h0, status_flags_r[1:0]});
      sv = status_flags_r;
      run(subroutine_return, 16'h0, 7'h00, 11'h0, 16'h0);
      chk("kept flags", {9'h0, sv}, {9'h0, status_flags_r});
      run(interrupt_return, 16'h0, 7'h00, 11'h0, 16'h0);
      chk("ie", 17'h1, {16'h0, status_flags_r[FLAG_I]});
      $display("product and return test done");
      w1c_mask = 8'h80;
      idle(8'h80);
      run(OP_IO_WRITE, 16'h4040, 7'h2e, 11'h0, 16'h1);
      run(OP_IO_READ, 16'h0, 7'h2e, 11'h0, 16'h1);
      chk("io", 17'hc0, {9'h0, io_rd_data_r});
      run(io_bit_set, 16'h0, 7'h0e, 11'h000, 16'h1);
      run(OP_IO_READ, 16'h0, 7'h2e, 11'h0, 16'h1);
      chk("io", 17'h41, {9'h0, io_rd_data_r});
      run(skip_port_bit_high, 16'h0, 7'h0e, 11'h700, 16'h3);
      run(skip_port_bit_low, 16'h0, 7'h0e, 11'h380, 16'h2);
      run(io_bit_clear, 16'h0, 7'h20, 11'h0, 16'h1);
      chk("refused", 17'h1, {16'h0, bad_addr_r});
      run(io_bit_clear, 16'h0, 7'h1f, 11'h0, 16'h1);
      chk("accepted", 17'h0, {16'h0, bad_addr_r});
      run(OP_IO_READ, 16'h0, 7'h3f, 11'h0, 16'h1);
      chk("cleared", 17'h0, {9'h0, io_rd_data_r});
      idle(8'h80);
      run(OP_IO_WRITE, 16'h00c1, 7'h2e, 11'h0, 16'h1);
      run(OP_IO_READ, 16'h0, 7'h2e, 11'h0, 16'h1);
      chk("w1c", 17'h41, {9'h0, io_rd_data_r});
      run(OP_IO_WRITE, 16'h00ff, 7'h5e, 11'h0, 16'h1);
      run(OP_IO_WRITE, 16'h0034, 7'h5d, 11'h0, 16'h1);
      chk("sp", 17'h734, {6'h0, stack_pointer_r});
      run(OP_IO_READ, 16'h0, 7'h5e, 11'h0, 16'h1);
      chk("sp high", 17'h7, {9'h0, io_rd_data_r});
      run(OP_IO_WRITE, 16'h0002, 7'h5f, 11'h0, 16'h1);
      run(branch_on_equal, 16'h0, 7'h00, 11'h07e, 16'hffff);
      run(OP_IO_READ, 16'h0, 7'h60, 11'h0, 16'h1);
      chk("data range", 17'h1, {16'h0, bad_addr_r});
      idle(8'h00);
      $display("io test done");
      summarize();
   end
   // hang guard
   initial begin
      repeat (4000) @(posedge sys_clk);
      errors++;
      summarize();
   end
endmodule
bind cpu_instruction_execute exec_checker chk_i (.sys_clk, .sys_rst,
   .issue_valid, .issue, .pc_now, .stack_pc, .result_r, .status_flags_r,
   .bad_addr_r);
